// ---- hw/chk_pkg.sv ----
// Purpose: Shared constants for the channel check and status register block
// Assumes: One 200 MHz clock; registers are 8 bits wide with odd read parity
// Notes:   Bit numbers follow the register layouts, bit 0 being the lsb here
package chk_pkg;
  localparam int unsigned REG_W      = 8;
  localparam int unsigned NUM_IFACE  = 8;
  localparam int unsigned IFACE_W    = 3;
  localparam int unsigned SEL_W      = 3;
  localparam int unsigned TAG_W      = 10;
  localparam int unsigned BUS_W      = 9;

  // Condition register select code that picks the interface check register
  localparam logic [SEL_W-1:0] SEL_IFACE_CHECK = 3'h0;

  // Interface check register bits
  localparam int unsigned CK_BUS_IN_PAR  = 0;
  localparam int unsigned CK_IFACE_CARD  = 1;
  localparam int unsigned CK_XFER_CARD   = 2;
  localparam int unsigned CK_SEARCH_CARD = 3;
  localparam int unsigned CK_CLK_AD      = 4;
  localparam int unsigned CK_CLK_EH      = 5;

  // Channel status two bits
  localparam int unsigned ST_HALT        = 0;
  localparam int unsigned ST_SEL_RESET   = 1;
  localparam int unsigned ST_SYS_RESET   = 2;
  localparam int unsigned ST_EXTRA_COND  = 3;
  localparam int unsigned ST_SEQ_CARD    = 4;
  localparam int unsigned ST_BUS_OUT_PAR = 5;
  localparam int unsigned ST_BASE_COND   = 6;
  localparam int unsigned ST_SUMMARY     = 7;

  // Bits cleared by a check reset in channel status two
  localparam logic [REG_W-1:0] CHECK_RESET_MASK = 8'hF0;
  localparam logic [REG_W-1:0] REG_CLEAR        = 8'h00;

  // Tag vector positions of the synchronised channel tags
  localparam int unsigned T_ADDR_OUT = 0;
  localparam int unsigned T_SEL_OUT  = 1;
  localparam int unsigned T_SUP_OUT  = 2;
  localparam int unsigned T_OP_OUT   = 3;
  localparam int unsigned T_CMD_OUT  = 4;
  localparam int unsigned T_OP_IN    = 5;
  localparam int unsigned T_ADDR_IN  = 6;
  localparam int unsigned T_STAT_IN  = 7;
  localparam int unsigned T_SVC_IN   = 8;
  localparam int unsigned T_DATA_IN  = 9;
endpackage

// ---- hw/sync_bank.sv ----
// Purpose: Two-stage synchroniser for a group of pin-level inputs
// Assumes: Inputs are levels from outside the clk_sys domain
// Notes:   The first stage feeds only the second stage
module sync_bank #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  // Per-bit two flip-flop chain, cleared by reset
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        stage_one[i] <= 1'b0;
        sync_out[i]  <= 1'b0;
      end else begin
        stage_one[i] <= pin_in[i];
        sync_out[i]  <= stage_one[i];
      end
    end
  end
endmodule

// ---- hw/iface_sysreset.sv ----
// Purpose: System reset latch of one channel interface
// Assumes: Tag inputs are already synchronised to clk_sys
// Notes:   The remembered operational out latch makes a disable act only once
module iface_sysreset (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic op_out,
  input  wire logic sup_out,
  input  wire logic iface_disable,
  input  wire logic initial_load_latch,
  input  wire logic taken,
  output logic      remember_op_out,
  output logic      sys_reset_latch
);
  logic op_out_delayed;
  logic channel_reset;
  logic disable_reset;

  // Channel reset: op out and suppress out both dropped after op out was up
  assign channel_reset = !op_out && !sup_out && remember_op_out && !op_out_delayed;
  // Disable resets only while op out is remembered
  assign disable_reset = iface_disable && remember_op_out;

  // Delayed copy of operational out
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      op_out_delayed <= 1'b0;
    end else begin
      op_out_delayed <= op_out;
    end
  end

  // Remember latch: armed by op out, spent by a channel or disable reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      remember_op_out <= 1'b0;
    end else if (op_out) begin
      remember_op_out <= 1'b1;
    end else if (channel_reset || disable_reset) begin
      remember_op_out <= 1'b0;
    end
  end

  // Latch holds until the interface is switched in; a new set beats the take
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sys_reset_latch <= 1'b0;
    end else if (channel_reset || disable_reset || initial_load_latch) begin
      sys_reset_latch <= 1'b1;
    end else if (taken) begin
      sys_reset_latch <= 1'b0;
    end
  end
endmodule

// ---- hw/channel_check_status_regs.sv ----
// Purpose: Interface check register and channel status two with summary check
// Assumes: Card fault inputs are clk_sys logic; channel tags and bus come from pins
// Notes:   Registers are reached by external load and read strobes only
module channel_check_status_regs (
  input  wire logic                               clk_sys,
  input  wire logic                               rst_n,
  // Register access
  input  wire logic                               cond_rd,
  input  wire logic                               cond_ld,
  input  wire logic                               status_rd,
  input  wire logic                               status_ld,
  input  wire logic [chk_pkg::SEL_W-1:0]          cond_select,
  output logic      [chk_pkg::REG_W-1:0]          rd_data,
  output logic                                    rd_parity,
  output logic                                    rd_valid,
  // Resets and maintenance commands
  input  wire logic                               check_reset,
  input  wire logic                               initial_load_reset,
  input  wire logic                               disable_recovery,
  input  wire logic                               load_maint_cmd,
  input  wire logic                               reset_maint_cmd,
  input  wire logic                               initial_load_done,
  // Feature straps
  input  wire logic                               feat_two_extra,
  input  wire logic                               feat_four_extra,
  // Channel pins of the switched interface
  input  wire logic [chk_pkg::TAG_W-1:0]          tag_pins,
  input  wire logic [chk_pkg::BUS_W-1:0]          bus_out_pins,
  input  wire logic                               data_xfer_active,
  // Per-interface pins and switching
  input  wire logic [chk_pkg::NUM_IFACE-1:0]      iface_op_out,
  input  wire logic [chk_pkg::NUM_IFACE-1:0]      iface_sup_out,
  input  wire logic [chk_pkg::NUM_IFACE-1:0]      iface_disable,
  input  wire logic                               iface_switch,
  input  wire logic [chk_pkg::IFACE_W-1:0]        iface_sel,
  // Card fault strobes
  input  wire logic                               bus_in_par_err,
  input  wire logic                               iface_card_fault,
  input  wire logic                               xfer_card_fault,
  input  wire logic                               search_card_fault,
  input  wire logic                               clk_check_ad,
  input  wire logic                               clk_check_eh,
  input  wire logic                               extra_cond_fault,
  input  wire logic                               seq_clock_fault,
  input  wire logic                               seq_select_fault,
  input  wire logic                               reg16_par_fault,
  input  wire logic                               control_one_par_fault,
  input  wire logic                               base_cond_fault,
  // Results
  output logic                                    new_level_one,
  output logic                                    check_two,
  output logic                                    xfer_err_bit0_set,
  output logic                                    xfer_err_bit3_set,
  output logic [chk_pkg::NUM_IFACE-1:0]           service_req,
  output logic                                    initial_load_latch
);
  logic [chk_pkg::REG_W-1:0]     channel_iface_check;
  logic [chk_pkg::REG_W-1:0]     channel_status_two;
  logic [chk_pkg::REG_W-1:0]     next_check;
  logic [chk_pkg::REG_W-1:0]     next_status;
  logic [chk_pkg::TAG_W-1:0]     tag;
  logic [chk_pkg::BUS_W-1:0]     bus_out;
  logic [2:0]                    iface_sync;
  logic [chk_pkg::NUM_IFACE-1:0] op_out_s;
  logic [chk_pkg::NUM_IFACE-1:0] sup_out_s;
  logic [chk_pkg::NUM_IFACE-1:0] disable_s;
  logic [chk_pkg::NUM_IFACE-1:0] remember;
  logic [chk_pkg::NUM_IFACE-1:0] sysreset;
  logic [chk_pkg::NUM_IFACE-1:0] taken;
  logic                          feat_two;
  logic                          feat_four;
  logic                          check_sel;
  logic                          check_clear;
  logic                          status_clear;
  logic                          addr_in_seen;
  logic                          bus_out_err;
  logic                          in_tag_err;
  logic                          summary_src;

  // Channel tags and bus pass two flops before any logic looks at them
  sync_bank #(.WIDTH(chk_pkg::TAG_W)) u_tag_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin_in   (tag_pins),
    .sync_out (tag)
  );
  sync_bank #(.WIDTH(chk_pkg::BUS_W)) u_bus_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin_in   (bus_out_pins),
    .sync_out (bus_out)
  );
  sync_bank #(.WIDTH(3*chk_pkg::NUM_IFACE)) u_iface_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin_in   ({iface_op_out, iface_sup_out, iface_disable}),
    .sync_out ({op_out_s, sup_out_s, disable_s})
  );
  sync_bank #(.WIDTH(3)) u_misc_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin_in   ({feat_two_extra, feat_four_extra, data_xfer_active}),
    .sync_out (iface_sync)
  );
  assign feat_two  = iface_sync[2];
  assign feat_four = iface_sync[1];

  // One system reset latch per interface, taken when switched in
  for (genvar i = 0; i < chk_pkg::NUM_IFACE; i++) begin : g_iface
    assign taken[i] = iface_switch && (iface_sel == chk_pkg::IFACE_W'(i));
    iface_sysreset u_sysreset (
      .clk_sys            (clk_sys),
      .rst_n              (rst_n),
      .op_out             (op_out_s[i]),
      .sup_out            (sup_out_s[i]),
      .iface_disable      (disable_s[i]),
      .initial_load_latch (initial_load_latch),
      .taken              (taken[i]),
      .remember_op_out    (remember[i]),
      .sys_reset_latch    (sysreset[i])
    );
  end

  // Initial load latch: set at power on and by maintenance commands
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      initial_load_latch <= 1'b1;
    end else if (load_maint_cmd || reset_maint_cmd) begin
      initial_load_latch <= 1'b1;
    end else if (initial_load_done) begin
      initial_load_latch <= 1'b0;
    end
  end

  // Service request is held off while the initial load latch is up
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      service_req <= '0;
    end else begin
      service_req <= initial_load_latch ? '0 : sysreset;
    end
  end

  // Bus-out parity is checked on command out after address in, or in transfer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addr_in_seen <= 1'b0;
    end else if (tag[chk_pkg::T_ADDR_IN]) begin
      addr_in_seen <= 1'b1;
    end else if (!tag[chk_pkg::T_CMD_OUT]) begin
      addr_in_seen <= 1'b0;
    end
  end
  assign bus_out_err = !(^bus_out) &&
                       ((tag[chk_pkg::T_CMD_OUT] && addr_in_seen) || iface_sync[0]);
  assign in_tag_err  = (tag[chk_pkg::T_ADDR_IN] || tag[chk_pkg::T_STAT_IN]) &&
                       (tag[chk_pkg::T_SVC_IN] || tag[chk_pkg::T_DATA_IN]);

  // Register select and clear terms
  assign check_sel    = (cond_select == chk_pkg::SEL_IFACE_CHECK);
  assign check_clear  = (cond_ld && check_sel) || check_reset;
  assign status_clear = status_ld || initial_load_reset || disable_recovery;

  // Next interface check value: hold, clear, then OR in new faults (set wins)
  always_comb begin
    next_check = check_clear ? chk_pkg::REG_CLEAR : channel_iface_check;
    next_check[chk_pkg::CK_BUS_IN_PAR]  = next_check[chk_pkg::CK_BUS_IN_PAR]  | bus_in_par_err;
    next_check[chk_pkg::CK_IFACE_CARD]  = next_check[chk_pkg::CK_IFACE_CARD]  | iface_card_fault;
    next_check[chk_pkg::CK_XFER_CARD]   = next_check[chk_pkg::CK_XFER_CARD]   | xfer_card_fault;
    next_check[chk_pkg::CK_SEARCH_CARD] = next_check[chk_pkg::CK_SEARCH_CARD] | search_card_fault;
    // Absent features leave their bits at zero
    next_check[chk_pkg::CK_CLK_AD] = next_check[chk_pkg::CK_CLK_AD] |
                                     (clk_check_ad && (feat_two || feat_four));
    next_check[chk_pkg::CK_CLK_EH] = next_check[chk_pkg::CK_CLK_EH] | (clk_check_eh && feat_four);
    next_check[7:6] = 2'h0;
  end

  // Next status value; a full clear, then check reset on the upper half
  always_comb begin
    next_status = status_clear ? chk_pkg::REG_CLEAR : channel_status_two;
    if (check_reset) begin
      next_status = next_status & ~chk_pkg::CHECK_RESET_MASK;
    end
    next_status[chk_pkg::ST_HALT] = next_status[chk_pkg::ST_HALT] |
      (tag[chk_pkg::T_ADDR_OUT] && tag[chk_pkg::T_OP_IN] && !tag[chk_pkg::T_SEL_OUT]);
    next_status[chk_pkg::ST_SEL_RESET] = next_status[chk_pkg::ST_SEL_RESET] |
      (tag[chk_pkg::T_SUP_OUT] && tag[chk_pkg::T_OP_IN] && !tag[chk_pkg::T_OP_OUT] &&
       remember[iface_sel]);
    next_status[chk_pkg::ST_SYS_RESET] = next_status[chk_pkg::ST_SYS_RESET] |
      (iface_switch && sysreset[iface_sel]);
    next_status[chk_pkg::ST_EXTRA_COND] = next_status[chk_pkg::ST_EXTRA_COND] |
      (extra_cond_fault && (feat_two || feat_four));
    next_status[chk_pkg::ST_SEQ_CARD] = next_status[chk_pkg::ST_SEQ_CARD] |
      seq_clock_fault | in_tag_err |
      seq_select_fault | reg16_par_fault | control_one_par_fault;
    next_status[chk_pkg::ST_BUS_OUT_PAR] = next_status[chk_pkg::ST_BUS_OUT_PAR] | bus_out_err;
    next_status[chk_pkg::ST_BASE_COND] = next_status[chk_pkg::ST_BASE_COND] | base_cond_fault;
    next_status[chk_pkg::ST_SUMMARY] = next_status[chk_pkg::ST_SUMMARY] | summary_src;
  end

  // Summary source uses only live register bits, so unused bits cannot feed it
  assign summary_src = (|next_check) | next_status[chk_pkg::ST_EXTRA_COND] |
                       next_status[chk_pkg::ST_SEQ_CARD] | next_status[chk_pkg::ST_BASE_COND];

  // Interface check register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      channel_iface_check <= chk_pkg::REG_CLEAR;
    end else begin
      channel_iface_check <= next_check;
    end
  end

  // Channel status two
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      channel_status_two <= chk_pkg::REG_CLEAR;
    end else begin
      channel_status_two <= next_status;
    end
  end

  // Level 1 interrupt request registers the next summary bit, in step with the summary register bit
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      new_level_one <= 1'b0;
    end else begin
      new_level_one <= next_status[chk_pkg::ST_SUMMARY];
    end
  end

  // Side effects toward the transfer error logic, registered copies one cycle behind their sources
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      check_two         <= 1'b0;
      xfer_err_bit0_set <= 1'b0;
      xfer_err_bit3_set <= 1'b0;
    end else begin
      check_two         <= bus_out_err;
      xfer_err_bit0_set <= bus_out_err;
      xfer_err_bit3_set <= seq_clock_fault;
    end
  end

  // Read port: data and parity both show the value before any same-cycle update
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_data   <= chk_pkg::REG_CLEAR;
      rd_parity <= 1'b1;
      rd_valid  <= 1'b0;
    end else if (status_rd) begin
      rd_data   <= channel_status_two;
      rd_parity <= ~^channel_status_two;
      rd_valid  <= 1'b1;
    end else if (cond_rd && check_sel) begin
      rd_data   <= channel_iface_check;
      rd_parity <= ~^channel_iface_check;
      rd_valid  <= 1'b1;
    end else begin
      rd_valid  <= 1'b0;
    end
  end

  property p_check_to_level_one;
    @(posedge clk_sys) disable iff (!rst_n)
    (bus_in_par_err && !check_reset && !status_clear) |=> new_level_one && channel_iface_check[0];
  endproperty
  a_check_to_level_one: assert property (p_check_to_level_one) else $error("check fault missed level 1");

  property p_select_gate;
    @(posedge clk_sys) disable iff (!rst_n)
    (cond_rd && !status_rd && cond_select != chk_pkg::SEL_IFACE_CHECK) |=> !rd_valid;
  endproperty
  a_select_gate: assert property (p_select_gate) else $error("check register read with wrong select");

  property p_check_holds;
    @(posedge clk_sys) disable iff (!rst_n)
    (!check_clear && channel_iface_check[2]) |=> channel_iface_check[2];
  endproperty
  a_check_holds: assert property (p_check_holds) else $error("check bit lost without clear");

  property p_unused_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    !feat_four |=> channel_iface_check[7:5] == 3'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused check bit set");

  property p_check_reset_low;
    @(posedge clk_sys) disable iff (!rst_n)
    (check_reset && !status_clear) |=>
      (channel_status_two[3:0] & $past(channel_status_two[3:0])) == $past(channel_status_two[3:0]);
  endproperty
  a_check_reset_low: assert property (p_check_reset_low) else $error("check reset disturbed low bits");

  property p_read_parity;
    @(posedge clk_sys) disable iff (!rst_n)
    status_rd |=> rd_valid && (^{rd_data, rd_parity}) && rd_data == $past(channel_status_two);
  endproperty
  a_read_parity: assert property (p_read_parity) else $error("status read parity not odd");

  property p_halt_set;
    @(posedge clk_sys) disable iff (!rst_n)
    (tag[chk_pkg::T_ADDR_OUT] && tag[chk_pkg::T_OP_IN] && !tag[chk_pkg::T_SEL_OUT]) |=> channel_status_two[0];
  endproperty
  a_halt_set: assert property (p_halt_set) else $error("halt bit not set");

  property p_service_held;
    @(posedge clk_sys) disable iff (!rst_n)
    initial_load_latch |=> service_req == '0;
  endproperty
  a_service_held: assert property (p_service_held) else $error("service request during initial load");

  property p_bus_out_side;
    @(posedge clk_sys) disable iff (!rst_n)
    bus_out_err |=> channel_status_two[5] && check_two && xfer_err_bit0_set ##1 (check_two == $past(bus_out_err));
  endproperty
  a_bus_out_side: assert property (p_bus_out_side) else $error("bus out parity effects wrong");

  property p_summary_level;
    @(posedge clk_sys) disable iff (!rst_n)
    channel_status_two[6] |-> channel_status_two[7] && new_level_one;
  endproperty
  a_summary_level: assert property (p_summary_level) else $error("summary or level 1 missing");
endmodule

// ---- dv/chan_host_model.sv ----
// Purpose: Host channel model driving the switched tags and bus out
// Assumes: cmd changes just after a rising edge
// Notes:   Bus out data moves every cycle so a stale byte is never trusted
module chan_host_model (
  input  wire logic       clk_sys,
  input  wire logic [1:0] cmd,
  output logic      [9:0] tag_pins,
  output logic      [8:0] bus_out_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] dat = 8'h00;
  // Halt pattern: address out with op in, select out low
  assign tag_pins = (cmd == 2'h1) ? 10'h021 : 10'h000;
  // Odd parity unless cmd 2 asks for a broken byte
  assign bus_out_pins = {(~^dat) ^ (cmd == 2'h2), dat};
  always @(posedge clk_sys) dat <= dat + 8'h35;
endmodule

// ---- dv/channel_check_status_regs_tb.sv ----
// Purpose: Self-checking bench for the check and status registers
// Assumes: Fault inputs are same-clock; tags cross two sync flops
// Notes:   Feature straps stay off, so feature bits must stay zero
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module channel_check_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst_n = 0, cond_rd = 0, cond_ld = 0, status_rd = 0, status_ld = 0;
  logic check_reset = 0, interrupt_level_reg = 0, dxa = 0, rd_parity, rd_valid, nl1, check_two;
  logic dr = 0, lmc = 0, ild = 0, isw = 0, ill, x0, x3;
  logic [2:0] isel = 3'h0, seen = 3'h0;
  logic [7:0] opo = 8'h00, sreq;
  logic [2:0] sel = 3'h0;
  logic [1:0] cmd = 2'h0;
  logic [11:0] flt = 12'h000;
  logic [7:0] rd_data;
  logic [9:0] tags;
  logic [8:0] bus;
  int n_mismatch = 0, n_compared = 0, cyc = 0, seed = 46123, ck = 0, st = 0;
  int map [12] = '{0, 1, 2, 3, -1, -1, -1, 12, 12, 12, 12, 14};
  initial forever #2.5 clk_sys = ~clk_sys;
  chan_host_model u_chan_host_model (.clk_sys(clk_sys), .cmd(cmd), .tag_pins(tags), .bus_out_pins(bus));
  channel_check_status_regs u_channel_check_status_regs (.clk_sys(clk_sys), .rst_n(rst_n),
    .cond_rd(cond_rd), .cond_ld(cond_ld), .status_rd(status_rd), .status_ld(status_ld),
    .cond_select(sel), .rd_data(rd_data), .rd_parity(rd_parity), .rd_valid(rd_valid),
    .check_reset(check_reset), .initial_load_reset(interrupt_level_reg), .disable_recovery(dr),
    .load_maint_cmd(lmc), .reset_maint_cmd(1'b0), .initial_load_done(ild),
    .feat_two_extra(1'b0), .feat_four_extra(1'b0), .tag_pins(tags), .bus_out_pins(bus),
    .data_xfer_active(dxa), .iface_op_out(opo), .iface_sup_out(8'h00), .iface_disable(8'h00),
    .iface_switch(isw), .iface_sel(isel), .bus_in_par_err(flt[0]), .iface_card_fault(flt[1]),
    .xfer_card_fault(flt[2]), .search_card_fault(flt[3]), .clk_check_ad(flt[4]),
    .clk_check_eh(flt[5]), .extra_cond_fault(flt[6]), .seq_clock_fault(flt[7]),
    .seq_select_fault(flt[8]), .reg16_par_fault(flt[9]), .control_one_par_fault(flt[10]),
    .base_cond_fault(flt[11]), .new_level_one(nl1), .check_two(check_two),
    .xfer_err_bit0_set(x0), .xfer_err_bit3_set(x3), .service_req(sreq), .initial_load_latch(ill));
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic hit(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
    step();
  endtask
  // One read strobe; data must reflect the model and carry odd parity
  task automatic rd(input logic stat, input int exp);
    status_rd = stat;
    cond_rd = !stat;
    step();
    status_rd = 1'b0;
    cond_rd = 1'b0;
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", exp[7:0], rd_data)
    `CHK("rd_parity", ~^exp[7:0], rd_parity)
  endtask
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog well above the roughly 110 cycles the sequence needs
  always @(posedge clk_sys) begin
    cyc++;
    seen <= seen | {x3, x0, check_two};
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    repeat (20) step();
    rst_n = 1'b1;
    repeat (3) step();
    rd(1'b1, 0);
    // Every fault input once; feature-gated ones must leave no trace
    for (int i = 0; i < 12; i++) begin
      flt[i] = 1'b1;
      step();
      flt = 12'h000;
      step();
      if (map[i] >= 8) st |= 1 << (map[i] - 8); else if (map[i] >= 0) ck |= 1 << map[i];
      if (map[i] != -1) st |= 8'h80;
      `CHK("new_level_one", st[7], nl1)
      rd(1'b1, st);
    end
    rd(1'b0, ck);
    // A non-zero select must neither read nor clear the check register
    sel = 3'h1 + 3'($unsigned($random(seed)) % 7);
    cond_rd = 1'b1;
    step();
    cond_rd = 1'b0;
    `CHK("refused_rd", 1'b0, rd_valid)
    hit(cond_ld);
    sel = 3'h0;
    rd(1'b0, ck);
    hit(cond_ld);
    rd(1'b0, 0);
    cmd = 2'h1;
    repeat (4) step();
    cmd = 2'h0;
    st |= 8'h01;
    hit(check_reset);
    st &= 8'h0F;
    rd(1'b1, st);
    hit(status_ld);
    rd(1'b1, 0);
    dxa = 1'b1;
    cmd = 2'h2;
    repeat (4) step();
    cmd = 2'h0;
    dxa = 1'b0;
    repeat (3) step();
    rd(1'b1, 8'h20);
    `CHK("check_two", 1'b1, seen[0])
    `CHK("xfer_err0", 1'b1, seen[1])
    `CHK("xfer_err3", 1'b1, seen[2])
    hit(dr);
    rd(1'b1, 0);
    // Initial load latch holds every interface's reset request back
    `CHK("initial_load_latch", 1'b1, ill)
    `CHK("service_req", 8'h00, sreq)
    hit(ild);
    `CHK("service_req", 8'hFF, sreq)
    isel = 3'($unsigned($random(seed)) % 8);
    hit(isw);
    `CHK("service_req", ~(8'h01 << isel), sreq)
    rd(1'b1, 8'h04);
    // Op out up then down on the switched-in interface re-arms its latch
    opo = 8'h01 << isel;
    repeat (4) step();
    opo = 8'h00;
    repeat (6) step();
    `CHK("service_req", 8'hFF, sreq)
    hit(lmc);
    `CHK("service_req", 8'h00, sreq)
    `CHK("initial_load_latch", 1'b1, ill)
    hit(interrupt_level_reg);
    rd(1'b1, 0);
    stop_test();
  end
endmodule
